// [rtl/sps_supervisor.sv]
`include "sps_regs.svh"
// Summary of operation
// - Built-in resistor: trip above about 1% duty.
// - External protected: trip above 10% active ratio.
// - External unprotected: regenerate, never trip.
// - No resistor: regeneration and protection both off.
// - Mains off after programmed absence, 2 ms units.
// - Mains time 1000 disables mains off detection.
// - Overtravel sequence 2 uses emergency torque limit.
// - Mains or servo-off sequence 8/9 likewise.
// - Emergency limit 0 means normal torque limit.
// - Deviation beyond threshold times 256 is error.
// - Deviation threshold 0 disables that error.
// - Overload level 0 means 115, clamped 115.
// - Overspeed 0 means 1.2x max, clamped there.
// - Overspeed tolerance 3 or 36 r/min.
// - Starred settings take effect at power-up.
module sps_supervisor
   import sps_pkg::*;
#(
   parameter int MAINS_UNIT_CYC = `SPS_MAINS_UNIT_CYC,
   parameter int DUTY_WIN       = `SPS_DUTY_WIN
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        regen_request,
   input  wire logic        mains_present,
   input  wire logic        overtravel_decel,
   input  wire logic        mains_off_decel,
   input  wire logic        servo_off_decel,
   input  wire logic [3:0]  overtravel_sequence_sel,
   input  wire logic [3:0]  mains_off_sequence_sel,
   input  wire logic [3:0]  servo_off_sequence_sel,
   input  wire logic [8:0]  normal_torque_limit,
   input  wire logic [31:0] deviation_count,
   input  wire logic [8:0]  motor_load,
   input  wire logic [14:0] motor_speed,
   input  wire logic [14:0] motor_max_speed,
   input  wire logic        encoder_absolute,
   output logic             regen_switch_on_ff,
   output logic [8:0]       torque_limit_ff,
   output logic             regen_overload_error_ff,
   output logic             mains_off_ff,
   output logic             deviation_excess_error_ff,
   output logic             overload_error_ff,
   output logic             overspeed_error_ff,
   output logic             irq_ff
);

////////////////////////////////////////////////////////////////////////////////
   // Software settings; the starred pair is staged and applied only at power-up.
   logic [1:0]  regen_resistor_sel_ff    = `SPS_RST_REGEN;
   logic [9:0]  mains_off_detect_time_ff = `SPS_RST_MAINS;
   logic [1:0]  act_regen_ff;
   logic [9:0]  act_mains_ff;
   logic [8:0]  estop_torque_limit_ff;
   logic [14:0] dev_thresh_ff;
   logic [8:0]  oload_set_ff;
   logic [14:0] ospeed_set_ff;
   logic [4:0]  status_ff;
   logic [4:0]  mask_ff;
   logic        boot_ff;
   logic        clear_ff;
   logic [31:0] wdata_ff;
   logic [11:0] awaddr_ff;
   logic        aw_hold_ff;
   logic        w_hold_ff;
   logic        wr_do;
   logic        rd_do;
   logic [4:0]  event_vec;
   logic [31:0] nxt_rdata;

   sps_regen_t regen_mode;
   assign regen_mode = sps_regen_t'(act_regen_ff);

////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data may arrive in either order.
   assign wr_do = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_ff    <= 1'b0;
         w_hold_ff     <= 1'b0;
         awaddr_ff     <= 12'h000;
         wdata_ff      <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
         end
         if (wr_do) begin
            aw_hold_ff   <= 1'b0;
            w_hold_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff[11:2] > `SPS_OFF_MASK >> 2) ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Byte strobes are ignored: every field sits in the low lanes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         estop_torque_limit_ff    <= 9'h000;
         dev_thresh_ff            <= `SPS_RST_DEVTH;
         oload_set_ff             <= 9'h000;
         ospeed_set_ff            <= 15'h0000;
         mask_ff                  <= 5'h00;
         clear_ff                 <= 1'b0;
      end else begin
         clear_ff <= 1'b0;
         if (wr_do) begin
            unique case (awaddr_ff)
               `SPS_OFF_CTRL:   clear_ff <= wdata_ff[0];
               `SPS_OFF_ESTOP: begin
                  if (wdata_ff[8:0] <= `SPS_ESTOP_MAX) begin
                     estop_torque_limit_ff <= wdata_ff[8:0];
                  end
               end
               `SPS_OFF_DEVTH:  dev_thresh_ff <= wdata_ff[14:0];
               `SPS_OFF_OLOAD:  oload_set_ff <= wdata_ff[8:0];
               `SPS_OFF_OSPEED: ospeed_set_ff <= wdata_ff[14:0];
               `SPS_OFF_MASK:   mask_ff <= wdata_ff[4:0];
               default: ;
            endcase
         end
      end
   end

   // Starred settings survive a control reset like retained storage; a reset here
   // would throw away every new value before the power-up copy could take it.
   always_ff @(posedge clk) begin
      if (wr_do && awaddr_ff == `SPS_OFF_REGEN) begin
         regen_resistor_sel_ff <= wdata_ff[1:0];
      end
      if (wr_do && awaddr_ff == `SPS_OFF_MAINS && wdata_ff[9:0] >= `SPS_RST_MAINS
          && wdata_ff[9:0] <= `SPS_MAINS_MAX) begin
         mains_off_detect_time_ff <= wdata_ff[9:0];
      end
   end

   // Starred settings are copied once after reset release.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_ff      <= 1'b1;
         act_regen_ff <= `SPS_RST_REGEN;
         act_mains_ff <= `SPS_RST_MAINS;
      end else begin
         boot_ff <= 1'b0;
         if (boot_ff) begin
            act_regen_ff <= regen_resistor_sel_ff;
            act_mains_ff <= mains_off_detect_time_ff;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Read channel; reading status clears it.
   assign rd_do = s_axi_arvalid && s_axi_arready;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
         `SPS_OFF_REGEN:  nxt_rdata = {30'h0, regen_resistor_sel_ff};
         `SPS_OFF_MAINS:  nxt_rdata = {22'h0, mains_off_detect_time_ff};
         `SPS_OFF_ESTOP:  nxt_rdata = {23'h0, estop_torque_limit_ff};
         `SPS_OFF_DEVTH:  nxt_rdata = {17'h0, dev_thresh_ff};
         `SPS_OFF_OLOAD:  nxt_rdata = {23'h0, oload_set_ff};
         `SPS_OFF_OSPEED: nxt_rdata = {17'h0, ospeed_set_ff};
         `SPS_OFF_STATUS: nxt_rdata = {27'h0, status_ff};
         `SPS_OFF_MASK:   nxt_rdata = {27'h0, mask_ff};
         `SPS_OFF_ACTIVE: nxt_rdata = {20'h0, act_mains_ff, act_regen_ff};
         `SPS_OFF_LIMIT:  nxt_rdata = {23'h0, torque_limit_ff};
         default:         nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= nxt_rdata;
            s_axi_rresp  <= (s_axi_araddr[11:2] > `SPS_OFF_LIMIT >> 2) ? 2'h2 : 2'h0;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Regeneration duty measured over a fixed window of control cycles.
   logic [13:0] win_cnt_ff;
   logic [13:0] on_cnt_ff;
   logic [7:0]  duty_lim;
   logic        regen_trip;
   logic        regen_allowed;

   assign regen_allowed = regen_mode != SPS_REGEN_NONE;
   assign duty_lim = (regen_mode == SPS_REGEN_BUILTIN) ? `SPS_BUILTIN_DUTY : `SPS_EXT_DUTY;
   assign regen_trip = ((regen_mode == SPS_REGEN_BUILTIN)
                        || (regen_mode == SPS_REGEN_EXT_PROT))
                       && (32'(on_cnt_ff) * 100 > 32'(duty_lim) * DUTY_WIN);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_ff         <= 14'h0000;
         on_cnt_ff          <= 14'h0000;
         regen_switch_on_ff <= 1'b0;
      end else begin
         regen_switch_on_ff <= regen_allowed && regen_request;
         if (32'(win_cnt_ff) >= DUTY_WIN - 1) begin
            win_cnt_ff <= 14'h0000;
            on_cnt_ff  <= 14'h0000;
         end else begin
            win_cnt_ff <= win_cnt_ff + 14'h0001;
            on_cnt_ff  <= on_cnt_ff + {13'h0000, regen_switch_on_ff};
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Mains absence timer: unit prescaler plus count of 2 ms units.
   logic [31:0] unit_cnt_ff;
   logic [9:0]  off_units_ff;
   logic        mains_trip;

   assign mains_trip = (act_mains_ff != `SPS_MAINS_OFF_CODE)
                       && (off_units_ff >= act_mains_ff);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_cnt_ff  <= 32'h0000_0000;
         off_units_ff <= 10'h000;
      end else if (mains_present) begin
         unit_cnt_ff  <= 32'h0000_0000;
         off_units_ff <= 10'h000;
      end else if (unit_cnt_ff >= 32'(MAINS_UNIT_CYC - 1)) begin
         unit_cnt_ff <= 32'h0000_0000;
         if (off_units_ff != 10'h3ff) begin
            off_units_ff <= off_units_ff + 10'h001;
         end
      end else begin
         unit_cnt_ff <= unit_cnt_ff + 32'h0000_0001;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Torque limit selection for emergency decelerations.
   logic estop_active;

   assign estop_active = (overtravel_decel && overtravel_sequence_sel == 4'h2)
      || (mains_off_decel && (mains_off_sequence_sel == 4'h8
                              || mains_off_sequence_sel == 4'h9))
      || (servo_off_decel && (servo_off_sequence_sel == 4'h8
                              || servo_off_sequence_sel == 4'h9));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         torque_limit_ff <= 9'h000;
      end else if (estop_active && estop_torque_limit_ff != 9'h000) begin
         torque_limit_ff <= estop_torque_limit_ff;
      end else begin
         torque_limit_ff <= normal_torque_limit;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // Deviation, overload and over-speed comparisons.
   logic        dev_trip;
   logic [8:0]  oload_lvl;
   logic [15:0] ospeed_ceil;
   logic [15:0] ospeed_lvl;
   logic [15:0] ospeed_thr;
   logic        ospeed_trip;

   // Threshold is in units of 256 counts; magnitude taken from a signed count.
   logic [31:0] dev_mag;
   assign dev_mag = deviation_count[31] ? (~deviation_count + 32'h1) : deviation_count;
   assign dev_trip = (dev_thresh_ff != 15'h0000)
                     && (dev_mag > {9'h000, dev_thresh_ff, 8'h00});

   assign oload_lvl = (oload_set_ff == 9'h000 || oload_set_ff > `SPS_OLOAD_DEF)
                      ? `SPS_OLOAD_DEF : oload_set_ff;

   assign ospeed_ceil = 16'(({5'h00, motor_max_speed} * 20'h00006) / 20'h00005);
   assign ospeed_lvl = (ospeed_set_ff == 15'h0000 || {1'b0, ospeed_set_ff} > ospeed_ceil)
                       ? ospeed_ceil : {1'b0, ospeed_set_ff};
   // Margin covers the feedback's own speed error so noise does not trip it.
   assign ospeed_thr = ospeed_lvl
                       + {10'h000, encoder_absolute ? `SPS_TOL_ABS : `SPS_TOL_INC};
   assign ospeed_trip = {1'b0, motor_speed} > ospeed_thr;

////////////////////////////////////////////////////////////////////////////////
   // Fault latches, sticky status, mask and interrupt.
   assign event_vec = {ospeed_trip, motor_load > oload_lvl, dev_trip, mains_trip, regen_trip};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regen_overload_error_ff   <= 1'b0;
         mains_off_ff              <= 1'b0;
         deviation_excess_error_ff <= 1'b0;
         overload_error_ff         <= 1'b0;
         overspeed_error_ff        <= 1'b0;
      end else begin
         // A new trip wins over a clear in the same cycle.
         regen_overload_error_ff   <= event_vec[`SPS_ST_REGEN] ||
                                      (regen_overload_error_ff && !clear_ff);
         mains_off_ff              <= event_vec[`SPS_ST_MAINS] || (mains_off_ff && !clear_ff);
         deviation_excess_error_ff <= event_vec[`SPS_ST_DEV] ||
                                      (deviation_excess_error_ff && !clear_ff);
         overload_error_ff         <= event_vec[`SPS_ST_OLOAD] ||
                                      (overload_error_ff && !clear_ff);
         overspeed_error_ff        <= event_vec[`SPS_ST_OSPEED] ||
                                      (overspeed_error_ff && !clear_ff);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= 5'h00;
         irq_ff    <= 1'b0;
      end else begin
         if (rd_do && s_axi_araddr == `SPS_OFF_STATUS) begin
            status_ff <= event_vec;
         end else begin
            status_ff <= status_ff | event_vec;
         end
         irq_ff <= |(status_ff & mask_ff);
      end
   end

////////////////////////////////////////////////////////////////////////////////
   mains_time_a: assert property (@(posedge clk) disable iff (!rst_n)
      (act_mains_ff == `SPS_MAINS_OFF_CODE) |=> !mains_off_ff || $past(mains_off_ff))
      else $error("mains off raised while detection disabled");

   dev_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dev_thresh_ff == 15'h0000 && !deviation_excess_error_ff) |=> !deviation_excess_error_ff)
      else $error("deviation error with threshold zero");

   dev_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dev_thresh_ff != 15'h0000 && dev_mag > {9'h000, dev_thresh_ff, 8'h00})
      |=> deviation_excess_error_ff)
      else $error("deviation excess not latched");

   estop_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      (estop_active && estop_torque_limit_ff != 9'h000)
      |=> torque_limit_ff == $past(estop_torque_limit_ff))
      else $error("emergency torque limit not applied");

   estop_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (estop_torque_limit_ff == 9'h000) |=> torque_limit_ff == $past(normal_torque_limit))
      else $error("normal limit not used");

   regen_none_a: assert property (@(posedge clk) disable iff (!rst_n)
      (regen_mode == SPS_REGEN_NONE) |=> !regen_switch_on_ff)
      else $error("regeneration active with no resistor");

   regen_noprot_a: assert property (@(posedge clk) disable iff (!rst_n)
      (regen_mode == SPS_REGEN_EXT_NOPROT && !regen_overload_error_ff)
      |=> !regen_overload_error_ff)
      else $error("regen trip in unprotected mode");

   oload_clamp_a: assert property (@(posedge clk) disable iff (!rst_n)
      oload_lvl <= `SPS_OLOAD_DEF && oload_lvl != 9'h000)
      else $error("overload level out of range");

   fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (overspeed_error_ff && !clear_ff) |=> overspeed_error_ff)
      else $error("fault dropped without clear");

   star_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !boot_ff |=> $stable(act_regen_ff) && $stable(act_mains_ff))
      else $error("starred setting changed after power-up");
endmodule

// [rtl/sps_regs.svh]
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
// Register byte offsets.
`define SPS_OFF_CTRL       12'h000
`define SPS_OFF_REGEN      12'h004
`define SPS_OFF_MAINS      12'h008
`define SPS_OFF_ESTOP      12'h00c
`define SPS_OFF_DEVTH      12'h010
`define SPS_OFF_OLOAD      12'h014
`define SPS_OFF_OSPEED     12'h018
`define SPS_OFF_STATUS     12'h01c
`define SPS_OFF_MASK       12'h020
`define SPS_OFF_ACTIVE     12'h024
`define SPS_OFF_LIMIT      12'h028
// Reset values, codes and limits.
`define SPS_RST_REGEN      2'h0
`define SPS_RST_MAINS      10'h023
`define SPS_RST_DEVTH      15'h61a8
`define SPS_MAINS_OFF_CODE 10'h3e8
`define SPS_MAINS_MAX      10'h3e8
`define SPS_ESTOP_MAX      9'h1f4
`define SPS_OLOAD_DEF      9'h073
`define SPS_OSPEED_MAX     15'h4e20
// Timing: mains unit in ns, cycle period in ns.
`define SPS_MAINS_UNIT_NS  2000000
`define SPS_CLK_NS         10
`define SPS_MAINS_UNIT_CYC (`SPS_MAINS_UNIT_NS / `SPS_CLK_NS)
// Regeneration duty limits in percent and window length.
`define SPS_BUILTIN_DUTY   8'h01
`define SPS_EXT_DUTY       8'h0a
`define SPS_DUTY_WIN       14'h2710
// Speed tolerance in r/min per encoder type.
`define SPS_TOL_ABS        6'h03
`define SPS_TOL_INC        6'h24
// Status bit positions.
`define SPS_ST_REGEN       0
`define SPS_ST_MAINS       1
`define SPS_ST_DEV         2
`define SPS_ST_OLOAD       3
`define SPS_ST_OSPEED      4
`endif

// [rtl/sps_pkg.sv]
package sps_pkg;
   typedef enum logic [1:0] {
      SPS_REGEN_BUILTIN,
      SPS_REGEN_EXT_PROT,
      SPS_REGEN_EXT_NOPROT,
      SPS_REGEN_NONE
   } sps_regen_t;
   typedef enum logic {SPS_WR_ADDR, SPS_WR_RESP} sps_wr_state_t;
endpackage

// [dv/sps_power_stage.sv]
module sps_power_stage (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [6:0] duty,
   output logic            regen_request
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] cnt_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Braking energy asks for the resistor a fixed share of every hundred cycles.
   // Counting from reset keeps the share exact in any window of that length.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 7'h00;
      end else begin
         cnt_ff <= (cnt_ff == 7'h63) ? 7'h00 : cnt_ff + 7'h01;
      end
   end
   assign regen_request = (cnt_ff < duty);
endmodule

// [dv/test_servo_protection_supervisor.sv]
`include "sps_regs.svh"
module test_servo_protection_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, regen_request, mains_present, overtravel_decel;
   logic        mains_off_decel, servo_off_decel, encoder_absolute, regen_switch_on_ff;
   logic        regen_overload_error_ff, mains_off_ff, deviation_excess_error_ff;
   logic        overload_error_ff, overspeed_error_ff, irq_ff;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, deviation_count, rd;
   logic [3:0]  s_axi_wstrb, overtravel_sequence_sel, mains_off_sequence_sel;
   logic [3:0]  servo_off_sequence_sel;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [8:0]  normal_torque_limit, motor_load, torque_limit_ff;
   logic [14:0] motor_speed, motor_max_speed;
   logic [6:0]  duty;
   int          num_errors, num_checks;
   sps_supervisor #(.MAINS_UNIT_CYC(4), .DUTY_WIN(100)) dut (.clk, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .regen_request, .mains_present,
      .overtravel_decel, .mains_off_decel, .servo_off_decel, .overtravel_sequence_sel,
      .mains_off_sequence_sel, .servo_off_sequence_sel, .normal_torque_limit, .deviation_count,
      .motor_load, .motor_speed, .motor_max_speed, .encoder_absolute, .regen_switch_on_ff,
      .torque_limit_ff, .regen_overload_error_ff, .mains_off_ff, .deviation_excess_error_ff,
      .overload_error_ff, .overspeed_error_ff, .irq_ff);
   sps_power_stage ps (.clk, .rst_n, .duty, .regen_request);
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      stop_test();
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chkb(input string n, input logic s, input logic e);
      chk(n, {31'h0, s}, {31'h0, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // The slave may take address and data on different edges, so each is
   // released on its own ready.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdw(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
      rdw(a);
      chk(n, rd, e);
   endtask
   // Drives load or speed to the limit, then one above it, then clears the fault.
   task automatic edge_test(input bit spd, input logic [14:0] lim);
      if (spd) motor_speed <= lim;
      else motor_load <= lim[8:0];
      cyc(3);
      chkb("trip_at_limit", spd ? overspeed_error_ff : overload_error_ff, 1'b0);
      if (spd) motor_speed <= lim + 15'h1;
      else motor_load <= lim[8:0] + 9'h1;
      cyc(3);
      chkb("trip_above", spd ? overspeed_error_ff : overload_error_ff, 1'b1);
      motor_speed <= 15'h0;
      motor_load <= 9'h0;
      wr(`SPS_OFF_CTRL, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, deviation_count, duty} = '0;
      {overtravel_decel, mains_off_decel, servo_off_decel, motor_load, motor_speed} = '0;
      {overtravel_sequence_sel, mains_off_sequence_sel, servo_off_sequence_sel} = '0;
      {mains_present, encoder_absolute, s_axi_wstrb} = 6'h3f;
      normal_torque_limit = 9'h12c;
      motor_max_speed = 15'h3e8;
      cyc(12);
      rst_n <= 1'b1;
      cyc(2);
      rchk("mains_reset", `SPS_OFF_MAINS, 32'h23);
      rchk("dev_reset", `SPS_OFF_DEVTH, 32'h61a8);
      rchk("active_reset", `SPS_OFF_ACTIVE, 32'h8c);
      rdw(12'h040);
      chk("rresp_unmapped", {30'h0, rsp}, 32'h2);
      wr(12'h030, 32'h1);
      chk("bresp_unmapped", {30'h0, rsp}, 32'h2);
      wr(`SPS_OFF_MASK, 32'h1f);
      mains_present <= 1'b0;
      cyc(130);
      chkb("mains_early", mains_off_ff, 1'b0);
      cyc(20);
      mains_present <= 1'b1;
      cyc(5);
      chkb("mains_latched", mains_off_ff, 1'b1);
      chkb("irq_set", irq_ff, 1'b1);
      rchk("status", `SPS_OFF_STATUS, 32'h2);
      rchk("status_clr", `SPS_OFF_STATUS, 32'h0);
      wr(`SPS_OFF_CTRL, 32'h1);
      cyc(3);
      chkb("irq_clr", irq_ff, 1'b0);
      duty <= 7'd1;
      cyc(300);
      chkb("regen_1pct", regen_overload_error_ff, 1'b0);
      duty <= 7'd2;
      cyc(250);
      chkb("regen_2pct", regen_overload_error_ff, 1'b1);
      duty <= 7'd100;
      cyc(3);
      chkb("regen_sw_on", regen_switch_on_ff, 1'b1);
      duty <= 7'd0;
      wr(`SPS_OFF_DEVTH, 32'h1);
      deviation_count <= 32'h100;
      cyc(3);
      chkb("dev_at", deviation_excess_error_ff, 1'b0);
      deviation_count <= 32'h101;
      cyc(3);
      chkb("dev_above", deviation_excess_error_ff, 1'b1);
      wr(`SPS_OFF_DEVTH, 32'h0);
      deviation_count <= 32'h7fffffff;
      wr(`SPS_OFF_CTRL, 32'h1);
      cyc(3);
      chkb("dev_off", deviation_excess_error_ff, 1'b0);
      deviation_count <= 32'h0;
      wr(`SPS_OFF_OLOAD, 32'd0);
      edge_test(1'b0, 15'd115);
      wr(`SPS_OFF_OLOAD, 32'd200);
      edge_test(1'b0, 15'd115);
      wr(`SPS_OFF_OLOAD, 32'd100);
      edge_test(1'b0, 15'd100);
      edge_test(1'b1, 15'd1203);
      encoder_absolute <= 1'b0;
      edge_test(1'b1, 15'd1236);
      wr(`SPS_OFF_OSPEED, 32'd500);
      edge_test(1'b1, 15'd536);
      wr(`SPS_OFF_ESTOP, 32'd100);
      wr(`SPS_OFF_ESTOP, 32'd501);
      rchk("estop_range", `SPS_OFF_ESTOP, 32'd100);
      overtravel_decel <= 1'b1;
      overtravel_sequence_sel <= 4'h2;
      cyc(3);
      rchk("limit_ot2", `SPS_OFF_LIMIT, 32'd100);
      overtravel_sequence_sel <= 4'h1;
      cyc(3);
      chk("limit_ot1", {23'h0, torque_limit_ff}, 32'd300);
      overtravel_decel <= 1'b0;
      for (int s = 8; s < 10; s++) begin
         mains_off_decel <= 1'b1;
         mains_off_sequence_sel <= 4'(s);
         cyc(3);
         chk("limit_mains", {23'h0, torque_limit_ff}, 32'd100);
         mains_off_decel <= 1'b0;
         servo_off_decel <= 1'b1;
         servo_off_sequence_sel <= 4'(s);
         cyc(3);
         chk("limit_servo", {23'h0, torque_limit_ff}, 32'd100);
      end
      wr(`SPS_OFF_ESTOP, 32'd0);
      cyc(3);
      chk("limit_zero", {23'h0, torque_limit_ff}, 32'd300);
      servo_off_decel <= 1'b0;
      for (int s = 1; s < 4; s++) begin
         wr(`SPS_OFF_REGEN, 32'(s));
         wr(`SPS_OFF_MAINS, 32'd1000);
         rchk("active_hold", `SPS_OFF_ACTIVE, (s == 1) ? 32'h8c : 32'hfa0 | 32'(s - 1));
         @(posedge clk);
         rst_n <= 1'b0;
         cyc(12);
         rst_n <= 1'b1;
         cyc(2);
         rchk("active_new", `SPS_OFF_ACTIVE, 32'hfa0 | 32'(s));
         mains_present <= 1'b0;
         duty <= 7'd5;
         cyc(250);
         chkb("regen_5pct", regen_overload_error_ff, 1'b0);
         duty <= 7'd20;
         cyc(250);
         chkb("regen_20pct", regen_overload_error_ff, s == 1);
         duty <= 7'd100;
         cyc(3);
         chkb("regen_sw", regen_switch_on_ff, s != 3);
         chkb("mains_never", mains_off_ff, 1'b0);
         duty <= 7'd0;
         mains_present <= 1'b1;
      end
      stop_test();
   end
endmodule
